/* src/dbgri_pkg.sv */
// Package for the debug reset interaction block: constants and carrier types.
// Assumes a single 100 MHz core clock and an asynchronous active-low reset.
package dbgri_pkg;

  // ---------------------------------------------------------------------------
  // Constants
  // ---------------------------------------------------------------------------
  localparam int  NUM_CPU_DEF       = 2;     // CPUs with checker cores
  localparam int  CORE_CLK_MHZ      = 100;
  localparam int  BOOT_STOP_NS      = 2000;  // Startup time before the retained halt bites
  localparam int  BOOT_STOP_CYC     = (BOOT_STOP_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int  APP_RST_MIN_NS    = 100;   // Least length of an app reset pulse
  localparam int  APP_RST_MIN_CYC   = (APP_RST_MIN_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int  SHIFT_W           = 2;     // Serial config word: bit0 request, bit1 halt
  localparam logic        RST_REQ   = 1'b0;
  localparam logic        RST_HALT  = 1'b0;
  localparam logic [11:0] RST_CNT   = 12'h000;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {DBGRI_RUN, DBGRI_RESET, DBGRI_BOOT, DBGRI_HALTED} dbgri_state_t;

  // Serial config link from the debug tool, as sampled pins
  typedef struct packed {
    logic clk;
    logic sel;
    logic dat;
  } dbgri_link_t;

endpackage

/* src/dbgri_top.sv */
// Debug reset interaction: app reset request from tool, retained debug halt,
// and post-reset lockstep alarm qualification per CPU.
// Assumes tool link pins are asynchronous; system reset request and CPU status
// come from logic on core_clk.
`timescale 1ns/1ps
module dbgri_top #(
  parameter int NUM_CPU = dbgri_pkg::NUM_CPU_DEF
) (
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  input  wire logic                debugResetPulse,
  input  wire dbgri_pkg::dbgri_link_t linkPins,
  input  wire logic                sysResetReq,
  input  wire logic                debugSystemEnable,
  input  wire logic [NUM_CPU-1:0]  lockstepEnable,
  input  wire logic [NUM_CPU-1:0]  cpuHalted,
  input  wire logic [NUM_CPU-1:0]  perfCountEnable,
  input  wire logic [NUM_CPU-1:0]  cycleCountRead,
  output logic                     appResetReq,
  output logic                     appResetActive,
  output logic                     bootCpuHalt,
  output logic                     debugHaltStatus,
  output logic [NUM_CPU-1:0]       lockstepAlarm
);

  // ---------------------------------------------------------------------------
  // Link synchronisers
  // ---------------------------------------------------------------------------
  logic [2:0] syncA_q, syncB_q;
  logic       linkClkOld_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA_q      <= 3'h0;
      syncB_q      <= 3'h0;
      linkClkOld_q <= 1'b0;
    end else begin
      syncA_q      <= linkPins;
      syncB_q      <= syncA_q;
      linkClkOld_q <= syncB_q[2];
    end
  end
  wire linkRise = syncB_q[2] & ~linkClkOld_q;
  wire linkSel  = syncB_q[1];
  wire linkDat  = syncB_q[0];

  // ---------------------------------------------------------------------------
  // Config word shifter; reset only by power-on/debug reset
  // ---------------------------------------------------------------------------
  logic [dbgri_pkg::SHIFT_W-1:0] shift_q, shift_d;
  logic                          selOld_q;
  logic                          req_q, req_d;
  logic                          halt_q, halt_d;
  // Word loads on the falling edge of select; the app reset never touches it
  always_comb begin
    shift_d = shift_q;
    req_d   = req_q;
    halt_d  = halt_q;
    if (linkSel && linkRise) begin
      shift_d = {linkDat, shift_q[dbgri_pkg::SHIFT_W-1:1]};
    end
    if (selOld_q && !linkSel) begin
      req_d  = shift_q[0];
      halt_d = shift_q[1];
    end
    if (debugResetPulse) begin
      req_d  = dbgri_pkg::RST_REQ;
      halt_d = dbgri_pkg::RST_HALT;
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_q  <= '0;
      selOld_q <= 1'b0;
      req_q    <= dbgri_pkg::RST_REQ;
      halt_q   <= dbgri_pkg::RST_HALT;
    end else begin
      shift_q  <= shift_d;
      selOld_q <= linkSel;
      req_q    <= req_d;
      halt_q   <= halt_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Reset sequencer and boot halt
  // ---------------------------------------------------------------------------
  dbgri_pkg::dbgri_state_t st_q, st_d;
  logic [11:0] cnt_q, cnt_d;
  logic [NUM_CPU-1:0] haltAtRst_q, haltAtRst_d;
  logic [NUM_CPU-1:0] alarm_q;
  wire logic [NUM_CPU-1:0] alarm_d;
  logic               resetEvt;
  // Reset holds while request stands; retained halt stops boot after a while
  always_comb begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    haltAtRst_d = haltAtRst_q;
    resetEvt    = 1'b0;
    case (st_q)
      dbgri_pkg::DBGRI_RUN, dbgri_pkg::DBGRI_HALTED: begin
        if (req_q || sysResetReq) begin
          resetEvt    = 1'b1;
          haltAtRst_d = cpuHalted;
          cnt_d       = dbgri_pkg::RST_CNT;
          st_d        = dbgri_pkg::DBGRI_RESET;
        end else if (st_q == dbgri_pkg::DBGRI_HALTED && !halt_q) begin
          st_d = dbgri_pkg::DBGRI_RUN;
        end
      end
      dbgri_pkg::DBGRI_RESET: begin
        if (cnt_q < 12'(dbgri_pkg::APP_RST_MIN_CYC)) begin
          cnt_d = cnt_q + 12'h001;
        end else if (!req_q) begin
          cnt_d = dbgri_pkg::RST_CNT;
          st_d  = dbgri_pkg::DBGRI_BOOT;
        end
      end
      dbgri_pkg::DBGRI_BOOT: begin
        if (!halt_q) begin
          st_d = dbgri_pkg::DBGRI_RUN;
        end else if (cnt_q >= 12'(dbgri_pkg::BOOT_STOP_CYC - 1)) begin
          st_d = dbgri_pkg::DBGRI_HALTED;
        end else begin
          cnt_d = cnt_q + 12'h001;
        end
      end
      default: st_d = dbgri_pkg::DBGRI_RUN;
    endcase
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q            <= dbgri_pkg::DBGRI_RUN;
      cnt_q           <= dbgri_pkg::RST_CNT;
      haltAtRst_q     <= '0;
      alarm_q         <= '0;
      appResetReq     <= 1'b0;
      appResetActive  <= 1'b0;
      bootCpuHalt     <= 1'b0;
      debugHaltStatus <= 1'b0;
      lockstepAlarm   <= '0;
    end else begin
      st_q            <= st_d;
      cnt_q           <= cnt_d;
      haltAtRst_q     <= haltAtRst_d;
      alarm_q         <= alarm_d;
      appResetReq     <= req_d;
      appResetActive  <= (st_d == dbgri_pkg::DBGRI_RESET);
      bootCpuHalt     <= (st_d == dbgri_pkg::DBGRI_HALTED);
      debugHaltStatus <= halt_d;
      lockstepAlarm   <= alarm_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Alarm qualification helpers
  // ---------------------------------------------------------------------------
  // Both enables must stand before any cause may raise a CPU's alarm.
  // Shared by the halt cause and the counter cause so they cannot drift apart.
  function automatic logic alarmAllowed(
    input logic lsEn,
    input logic dbgEn
  );
    return lsEn & dbgEn;
  endfunction

  // First cycle after the reset ends: the one moment the halt cause is judged.
  // Judging it once keeps a long boot from re-arming a cleared alarm.
  wire logic bootFirst = (st_q == dbgri_pkg::DBGRI_BOOT) && (cnt_q == dbgri_pkg::RST_CNT);

  // ---------------------------------------------------------------------------
  // Per-CPU lockstep alarm
  // ---------------------------------------------------------------------------
  // Each checker-equipped CPU has its own sticky alarm bit.
  // Reset entry clears the old alarm, but a cause in that same cycle still
  // wins, so a counter read that coincides with the reset is never lost.
  genvar g;
  generate
    for (g = 0; g < NUM_CPU; g++) begin : gen_alarm
      wire logic enabled;
      wire logic haltCause;
      wire logic countCause;
      wire logic kept;
      // Enables of this CPU and of the debug system
      assign enabled    = alarmAllowed(lockstepEnable[g], debugSystemEnable);
      // CPU was stopped when the reset hit
      assign haltCause  = bootFirst & enabled & haltAtRst_q[g];
      // Counters on and cycle count register read
      assign countCause = enabled & perfCountEnable[g] & cycleCountRead[g];
      // Old alarm survives unless a new reset starts
      assign kept       = resetEvt ? 1'b0 : alarm_q[g];
      // Set wins over the reset-entry clear
      assign alarm_d[g] = kept | haltCause | countCause;
    end
  endgenerate

endmodule

/* verification/dbgri_checker.sv */
// Checker for the dbgri_top ports: reset hold, retained bits, boot halt, alarms.
// Assumes it is bound onto every dbgri_top instance.
`timescale 1ns/1ps
module dbgri_checker #(parameter int NUM_CPU = 2) (
  input wire logic                   core_clk,
  input wire logic                   arst_n,
  input wire logic                   debugResetPulse,
  input wire dbgri_pkg::dbgri_link_t linkPins,
  input wire logic                   sysResetReq,
  input wire logic                   debugSystemEnable,
  input wire logic [NUM_CPU-1:0]     lockstepEnable,
  input wire logic [NUM_CPU-1:0]     cpuHalted,
  input wire logic [NUM_CPU-1:0]     perfCountEnable,
  input wire logic [NUM_CPU-1:0]     cycleCountRead,
  input wire logic                   appResetReq,
  input wire logic                   appResetActive,
  input wire logic                   bootCpuHalt,
  input wire logic                   debugHaltStatus,
  input wire logic [NUM_CPU-1:0]     lockstepAlarm
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Link idle long enough that no word is still on its way
  sequence linkQuiet; (!linkPins.sel)[*8]; endsequence
  chk_req_holds: assert property (appResetReq |=> appResetActive) else $error("reset not held");
  chk_reset_min: assert property ($rose(appResetActive) |-> appResetActive[*8]) else $error("reset short");
  chk_release_ends: assert property (appResetActive && !appResetReq && !sysResetReq |-> ##[0:12] !appResetActive)
    else $error("reset stuck");
  chk_req_kept: assert property (linkQuiet ##0 (appResetReq && !debugResetPulse) |=> appResetReq)
    else $error("request lost");
  chk_halt_kept: assert property (linkQuiet ##0 (debugHaltStatus && !debugResetPulse) |=> debugHaltStatus)
    else $error("halt lost");
  chk_debug_clears: assert property (debugResetPulse |-> ##[1:2] (!debugHaltStatus && !appResetReq))
    else $error("bits not cleared");
  chk_boot_runs: assert property ($fell(appResetActive) |-> !bootCpuHalt[*8]) else $error("no startup");
  chk_boot_stops: assert property ($fell(appResetActive) && debugHaltStatus |-> ##[150:260] bootCpuHalt)
    else $error("no boot stop");
  chk_alarm_cause: assert property ($rose(lockstepAlarm[0]) |-> $past(lockstepEnable[0] && debugSystemEnable))
    else $error("alarm without enables");
  chk_alarm_perf: assert property (lockstepEnable[1] && debugSystemEnable && perfCountEnable[1] && cycleCountRead[1]
    |-> ##[1:2] lockstepAlarm[1]) else $error("no counter alarm");
endmodule
bind dbgri_top dbgri_checker #(.NUM_CPU(NUM_CPU)) u_chk (.core_clk, .arst_n, .debugResetPulse, .linkPins,
  .sysResetReq, .debugSystemEnable, .lockstepEnable, .cpuHalted, .perfCountEnable, .cycleCountRead,
  .appResetReq, .appResetActive, .bootCpuHalt, .debugHaltStatus, .lockstepAlarm);

/* verification/dbgri_tool.sv */
// Debug tool model: writes config words over the serial link.
// Assumes the bench calls sendWord; the link clock stands still between words.
`timescale 1ns/1ps
module dbgri_tool (
  output dbgri_pkg::dbgri_link_t linkPins
);
  localparam realtime HALF = 62.5; // 8 MHz link, well above the 1 MHz floor
  initial linkPins = 3'h1;
  // Shift request then halt bit, LSB first; word applies on select fall
  task automatic sendWord(input logic req, input logic halt);
    logic [1:0] w;
    w = {halt, req};
    linkPins.sel = 1'b1;
    for (int i = 0; i < 2; i++) begin
      linkPins.dat = w[i];
      #HALF linkPins.clk = 1'b1;
      #HALF linkPins.clk = 1'b0;
    end
    #HALF linkPins.sel = 1'b0;
    linkPins.dat = ~w[1]; // Released line shows no stale value
  endtask
endmodule

/* verification/dbgri_top_test.sv */
// Bench for dbgri_top: tool reset requests, retained halt, boot stop, alarms.
// Assumes dbgri_tool drives the link and dbgri_checker is bound.
`timescale 1ns/1ps
module dbgri_top_test;
  logic coreClk = 1'b0, arstN = 1'b0, dbgRst = 1'b0, sysRst = 1'b0, dbgEn = 1'b0;
  logic [1:0] lsEn = 2'h0, halted = 2'h0, perfEn = 2'h0, ccRead = 2'h0;
  logic req, active, bootHalt, haltSt;
  logic [1:0] alarm;
  dbgri_pkg::dbgri_link_t link;
  int nErrors = 0, samplesChecked = 0, cycles = 0;
  always #5 coreClk = ~coreClk;
  dbgri_tool u_tool (.linkPins(link));
  dbgri_top u_dut (.core_clk(coreClk), .arst_n(arstN), .debugResetPulse(dbgRst), .linkPins(link),
    .sysResetReq(sysRst), .debugSystemEnable(dbgEn), .lockstepEnable(lsEn), .cpuHalted(halted),
    .perfCountEnable(perfEn), .cycleCountRead(ccRead), .appResetReq(req), .appResetActive(active),
    .bootCpuHalt(bootHalt), .debugHaltStatus(haltSt), .lockstepAlarm(alarm));
  task automatic tick(input int n);
    repeat (n) @(posedge coreClk);
    #1;
  endtask
  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nErrors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge coreClk) begin
    cycles++;
    if (cycles == 3000) begin
      nErrors++;
      conclude();
    end
  end
  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    tick(2);
    arstN = 1'b1;
    lsEn = 2'h3;
    dbgEn = 1'b1;
    halted = 2'h1;
    u_tool.sendWord(1'b1, 1'b1);
    tick(6);
    check({req, active}, 2'h3);
    tick(40);
    check({req, active}, 2'h3);
    $display("test request done");
    u_tool.sendWord(1'b0, 1'b1);
    u_tool.sendWord(1'b0, 1'b1);
    tick(40);
    check({active, bootHalt}, 2'h0);
    check(alarm, 2'h1);
    tick(200);
    check({bootHalt, haltSt}, 2'h3);
    $display("test release done");
    halted = 2'h0;
    dbgEn = 1'b0;
    sysRst = 1'b1;
    tick(1);
    sysRst = 1'b0;
    tick(30);
    check({active, haltSt}, 2'h1);
    check(alarm, 2'h0);
    dbgEn = 1'b1;
    perfEn = 2'h2;
    ccRead = 2'h2;
    tick(3);
    check(alarm, 2'h2);
    $display("test system reset done");
    tick(200);
    dbgRst = 1'b1;
    tick(1);
    dbgRst = 1'b0;
    tick(2);
    check({haltSt, req}, 2'h0);
    check({bootHalt, active}, 2'h0);
    $display("test debug reset done");
    perfEn = 2'h0;
    ccRead = 2'h0;
    u_tool.sendWord(1'b0, 1'b0);
    tick(10);
    sysRst = 1'b1;
    tick(1);
    sysRst = 1'b0;
    tick(250);
    check({active, bootHalt}, 2'h0);
    check(alarm, 2'h0);
    $display("test clean reset done");
    conclude();
  end
endmodule
